/* alpf_conv.sv */
// converter end: conversion flow control and its low-power handling
// assumes requests are synchronous levels on i_ref_clk
`timescale 1ns/1ps
`include "alpf_regs.svh"
module alpf_conv #(
  parameter int CONV_CYCLES = `ALPF_CONV_CYCLES
) (
  // clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  // link
  alpf_if.conv                             lnk,
  // configuration
  input  wire logic                        i_store_on_abort,
  input  wire logic                        i_stop_in_wait,
  input  wire logic                        i_auto_restart_after_lowpower,
  input  wire logic                        i_freeze_behavior_select,
  input  wire logic                        i_trigger_mode,
  input  wire logic [1:0]                  i_access_cfg,
  input  wire logic                        i_list_end,
  // bus writes to flow bits
  input  wire logic                        i_wr_restart,
  input  wire logic                        i_wr_trigger,
  input  wire logic                        i_wr_abort,
  input  wire logic                        i_wr_load_ok,
  // status
  output logic [3:0]                       o_flow_bits,
  output logic [`ALPF_COMMAND_INDEX_W-1:0]       o_command_index,
  output logic [`ALPF_COMMAND_INDEX_W-1:0]       o_result_index,
  output logic                             o_result_buffer_select,
  output logic                             o_result_store,
  output logic                             o_abort_done_flag,
  output logic                             o_conv_done_flag,
  output logic                             o_ready
);
  initial
  begin
    if (CONV_CYCLES < 1 || CONV_CYCLES > 255)
    begin
      $error("CONV_CYCLES out of range");
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    alpf_pkg::alpf_state_type        state;
    logic [7:0]                      cnt;
    logic                            restart_r;
    logic                            trigger_r;
    logic                            abort_r;
    logic                            load_ok_r;
    logic                            sw_abort;
    logic                            pend_restart;
    logic                            pend_auto;
    logic                            halt_req;
    logic [`ALPF_COMMAND_INDEX_W-1:0]      command_index;
    logic [`ALPF_COMMAND_INDEX_W-1:0]      res_idx;
    logic                            rbuf_sel;
    logic                            store;
    logic                            abort_done;
    logic                            conv_done;
  } alpf_conv_st_type;
  alpf_conv_st_type st_r;
  alpf_conv_st_type st_nxt;
  logic lp_req;
  logic bus_en;
  logic if_en;
  logic conv_end;
  logic set_rst;
  logic set_trg;
  logic set_abt;
  logic set_lok;
  assign lp_req   = lnk.stop_req | (lnk.wait_req & i_stop_in_wait);
  assign bus_en   = i_access_cfg[1];
  assign if_en    = i_access_cfg[0];
  assign set_rst  = (bus_en & i_wr_restart) | (if_en & lnk.restart_sig);
  assign set_trg  = (bus_en & i_wr_trigger) | (if_en & lnk.trigger_sig);
  assign set_abt  = (bus_en & i_wr_abort)   | (if_en & lnk.abort_sig);
  assign set_lok  = (bus_en & i_wr_load_ok) | (if_en & lnk.load_ok_sig);
  assign conv_end = (st_r.cnt == 8'(CONV_CYCLES - 1));
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.store      = 1'b0;
    st_nxt.abort_done = 1'b0;
    st_nxt.conv_done  = 1'b0;
    if (!lp_req && st_r.state != alpf_pkg::ST_LOWPWR)
    begin
      st_nxt.restart_r = st_r.restart_r | set_rst;
      st_nxt.trigger_r = st_r.trigger_r | set_trg;
      st_nxt.abort_r   = st_r.abort_r   | set_abt;
      st_nxt.load_ok_r = st_r.load_ok_r | set_lok;
    end
    else if (set_rst && st_r.state == alpf_pkg::ST_ABORT)
    begin
      st_nxt.pend_restart = 1'b1;
    end
    // halt request follows freeze while i_freeze_behavior_select is low, so a list that ends first leaves none behind
    st_nxt.halt_req = lnk.freeze_req & ~i_freeze_behavior_select;
    case (st_r.state)
      alpf_pkg::ST_IDLE:
      begin
        if (lp_req)
        begin
          st_nxt.state = alpf_pkg::ST_LOWPWR;
        end
        else if (st_r.restart_r || st_nxt.restart_r)
        begin
          st_nxt.command_index   = '0;
          st_nxt.res_idx   = '0;
          st_nxt.restart_r = 1'b0;
          st_nxt.abort_r   = 1'b0;
        end
        else if (st_r.trigger_r)
        begin
          st_nxt.trigger_r = 1'b0;
          st_nxt.load_ok_r = 1'b0;
          st_nxt.cnt       = '0;
          st_nxt.state     = alpf_pkg::ST_CONV;
        end
      end
      alpf_pkg::ST_CONV:
      begin
        if (lp_req || st_r.abort_r)
        begin
          st_nxt.sw_abort = ~lp_req;
          st_nxt.abort_r  = 1'b0;
          st_nxt.state    = alpf_pkg::ST_ABORT;
        end
        if (st_r.halt_req && conv_end)
        begin
          st_nxt.state = alpf_pkg::ST_FROZEN;
        end
        st_nxt.cnt = st_r.cnt + 8'h01;
        if (conv_end)
        begin
          st_nxt.cnt       = '0;
          st_nxt.store     = 1'b1;
          st_nxt.conv_done = 1'b1;
          st_nxt.command_index   = st_r.command_index + 1'b1;
          st_nxt.res_idx   = st_r.res_idx + 1'b1;
          if (i_list_end || st_r.command_index == `ALPF_CMD_LAST)
          begin
            st_nxt.rbuf_sel = ~st_r.rbuf_sel;
            st_nxt.state    = alpf_pkg::ST_IDLE;
          end
        end
      end
      alpf_pkg::ST_ABORT:
      begin
        st_nxt.cnt = st_r.cnt + 8'h01;
        if (conv_end)
        begin
          st_nxt.store      = i_store_on_abort;
          st_nxt.conv_done  = i_store_on_abort;
          st_nxt.cnt        = '0;
          // done flag only for software abort
          st_nxt.abort_done = st_r.sw_abort;
          st_nxt.sw_abort   = 1'b0;
          st_nxt.state      = lp_req ? alpf_pkg::ST_LOWPWR : alpf_pkg::ST_IDLE;
          if (st_r.pend_restart && !lp_req)
          begin
            st_nxt.restart_r    = 1'b1;
            st_nxt.pend_restart = 1'b0;
          end
        end
      end
      alpf_pkg::ST_LOWPWR:
      begin
        if (!lp_req)
        begin
          st_nxt.state = alpf_pkg::ST_IDLE;
          if (i_auto_restart_after_lowpower || st_r.pend_restart)
          begin
            st_nxt.restart_r    = 1'b1;
            st_nxt.trigger_r    = i_trigger_mode & i_auto_restart_after_lowpower;
            st_nxt.pend_restart = 1'b0;
          end
        end
      end
      alpf_pkg::ST_FROZEN:
      begin
        // resume at next command, flags kept
        if (!lnk.freeze_req)
        begin
          st_nxt.halt_req = 1'b0;
          st_nxt.state    = alpf_pkg::ST_CONV;
        end
      end
      default:
      begin
        st_nxt.state = alpf_pkg::ST_IDLE;
      end
    endcase
    if (lp_req || st_nxt.state == alpf_pkg::ST_LOWPWR)
    begin
      // flow bits cleared in low power
      st_nxt.restart_r = 1'b0;
      st_nxt.trigger_r = 1'b0;
      st_nxt.abort_r   = 1'b0;
      st_nxt.load_ok_r = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '{state: alpf_pkg::ST_IDLE, cnt: 8'h00, default: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // ready only in idle or low power
  assign o_ready                = (st_r.state == alpf_pkg::ST_IDLE) | (st_r.state == alpf_pkg::ST_LOWPWR);
  assign lnk.ready              = o_ready;
  assign lnk.busy               = (st_r.state == alpf_pkg::ST_CONV) | (st_r.state == alpf_pkg::ST_ABORT);
  assign lnk.lowpower_ack       = (st_r.state == alpf_pkg::ST_LOWPWR);
  assign o_flow_bits            = {st_r.abort_r, st_r.trigger_r, st_r.restart_r, st_r.load_ok_r};
  assign o_command_index        = st_r.command_index;
  assign o_result_index         = st_r.res_idx;
  assign o_result_buffer_select = st_r.rbuf_sel;
  assign o_result_store         = st_r.store;
  assign o_abort_done_flag      = st_r.abort_done;
  assign o_conv_done_flag       = st_r.conv_done;
endmodule : alpf_conv

/* alpf_ctrl.sv */
// mode controller / trigger end driving the converter link
// assumes the converter end answers on the same clock
`timescale 1ns/1ps
module alpf_ctrl (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // link
  alpf_if.ctrl      lnk,
  // user requests
  input  wire logic i_stop,
  input  wire logic i_wait,
  input  wire logic i_freeze,
  input  wire logic i_stop_in_wait,
  input  wire logic i_trigger_mode,
  input  wire logic i_restart,
  input  wire logic i_trigger,
  input  wire logic i_abort,
  input  wire logic i_load_ok,
  // status
  output logic      o_in_lowpower,
  output logic      o_busy
);
  typedef struct packed {
    logic stop;
    logic waitm;
    logic freeze;
    logic restart;
    logic trigger;
    logic abort;
    logic load_ok;
  } alpf_ctrl_st_type;
  alpf_ctrl_st_type st_r;
  alpf_ctrl_st_type st_nxt;
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = '0;
    // synchronous level requests; converter aborts by itself if busy
    st_nxt.stop    = i_stop;
    st_nxt.waitm   = i_wait;
    st_nxt.freeze  = i_freeze;
    // lowpower request masks software abort; plain wait keeps the converter running
    st_nxt.abort   = i_abort & ~(i_stop | (i_wait & i_stop_in_wait));
    // trigger from i_trigger, and also with restart in trigger mode
    st_nxt.restart = i_restart;
    st_nxt.trigger = i_trigger | (i_restart & i_trigger_mode);
    // keep servicing flow bits in wait
    st_nxt.load_ok = i_load_ok;
    if (i_restart && !i_trigger_mode)
    begin
      st_nxt.abort = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  assign lnk.stop_req    = st_r.stop;
  assign lnk.wait_req    = st_r.waitm;
  assign lnk.freeze_req  = st_r.freeze;
  assign lnk.restart_sig = st_r.restart;
  assign lnk.trigger_sig = st_r.trigger;
  assign lnk.abort_sig   = st_r.abort;
  assign lnk.load_ok_sig = st_r.load_ok;
  assign o_in_lowpower   = lnk.lowpower_ack;
  assign o_busy          = lnk.busy;
endmodule : alpf_ctrl

/* alpf_if.sv */
// link between converter flow control and the mode controller / trigger side
// assumes one clock and synchronous level requests
`timescale 1ns/1ps
interface alpf_if;
  logic stop_req;
  logic wait_req;
  logic freeze_req;
  logic restart_sig;
  logic trigger_sig;
  logic abort_sig;
  logic load_ok_sig;
  logic ready;
  logic busy;
  logic lowpower_ack;
  modport conv (input stop_req, wait_req, freeze_req, restart_sig, trigger_sig, abort_sig, load_ok_sig,
                output ready, busy, lowpower_ack);
  modport ctrl (output stop_req, wait_req, freeze_req, restart_sig, trigger_sig, abort_sig, load_ok_sig,
                input ready, busy, lowpower_ack);
endinterface : alpf_if

/* alpf_pkg.sv */
// state type used by the converter end of the low-power flow control pair
// assumes alpf_regs.svh is on the include path
`include "alpf_regs.svh"
package alpf_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONV,
    ST_ABORT,
    ST_LOWPWR,
    ST_FROZEN
  } alpf_state_type;
endpackage : alpf_pkg

/* alpf_properties.sv */
// checker for the link between converter end and mode controller end
// assumes the link signals arrive as plain inputs on one clock
`timescale 1ns/1ps
module alpf_properties #(
  parameter int CONV_CYCLES = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // link
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic freeze_req,
  input wire logic trigger_sig,
  input wire logic ready,
  input wire logic busy,
  input wire logic lowpower_ack
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  // length of the current busy run, to see conversions finish whole
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  always_comb run_nxt = busy ? run_r + 8'h01 : 8'h00;
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst) run_r <= 8'h00;
    else run_r <= run_nxt;
  ////////////////////////////////////////////////////////////
  a_lp_not_busy: assert property (lowpower_ack |-> !busy)
    else $error("busy while in low power");
  a_ack_has_req: assert property ($rose(lowpower_ack) |-> stop_req || wait_req)
    else $error("low power entered without request");
  a_ack_release: assert property (lowpower_ack && !stop_req && !wait_req |=> !lowpower_ack)
    else $error("low power kept after request fell");
  a_stop_held: assert property (stop_req && busy |=> stop_req)
    else $error("stop dropped while converter busy");
  a_abort_bounded: assert property (stop_req && busy |-> ##[1:10] !busy)
    else $error("abort did not finish in time");
  a_idle_stop: assert property (stop_req && !busy && !lowpower_ack |-> ##[1:2] lowpower_ack)
    else $error("idle converter missed stop");
  a_ready_abort: assert property (stop_req && busy && $past(stop_req) && $past(busy) |-> !ready)
    else $error("ready shown during abort");
  a_trigger_bit_start: assert property (trigger_sig && !busy && !lowpower_ack && !stop_req && !wait_req
                                 && !freeze_req |-> ##[1:4] busy)
    else $error("trigger did not start conversion");
  a_conv_whole: assert property ($fell(busy) |-> run_r >= CONV_CYCLES)
    else $error("conversion cut short");
  c_lowpower: cover property ($rose(lowpower_ack));
  c_stop_busy: cover property (stop_req && busy);
  c_freeze_busy: cover property (freeze_req && busy);
endmodule : alpf_properties

/* alpf_regs.svh */
// timing counts and reset values for the low-power flow control pair
// assumes inclusion by bare name from package and modules
`ifndef ALPF_REGS_SVH
`define ALPF_REGS_SVH
`define ALPF_CONV_CYCLES      8
`define ALPF_COMMAND_INDEX_W        6
`define ALPF_CMD_LAST         6'h3f
`define ALPF_FLOW_RST         4'h0
`endif

/* tb.sv */
// self-checking bench joining converter end and controller end
// assumes 50 MHz clock, inputs driven on the falling edge
`timescale 1ns/1ps
module tb;
  logic       i_ref_clk, i_rst, store, siw, autor, frzsel, tmode, list_end;
  logic [1:0] acc;
  logic       wr_rst, wr_trg, wr_abt, wr_load_ok_bit, stop, wt, frz, rst_r, trg, abt, load_ok_bit;
  logic [3:0] flow;
  logic [5:0] cidx, ridx;
  logic       bsel, rstore, adone, cdone, rdy, in_lp, cbusy, sel0;
  int         err_count, n_compared, cyc, n_store, n_adone, n_cdone;
  alpf_if lnk();
  alpf_conv #(.CONV_CYCLES(8)) i_alpf_conv (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .lnk(lnk),
    .i_store_on_abort(store), .i_stop_in_wait(siw), .i_auto_restart_after_lowpower(autor),
    .i_freeze_behavior_select(frzsel), .i_trigger_mode(tmode), .i_access_cfg(acc), .i_list_end(list_end),
    .i_wr_restart(wr_rst), .i_wr_trigger(wr_trg), .i_wr_abort(wr_abt), .i_wr_load_ok(wr_load_ok_bit),
    .o_flow_bits(flow), .o_command_index(cidx), .o_result_index(ridx), .o_result_buffer_select(bsel),
    .o_result_store(rstore), .o_abort_done_flag(adone), .o_conv_done_flag(cdone), .o_ready(rdy));
  alpf_ctrl i_alpf_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .lnk(lnk), .i_stop(stop), .i_wait(wt),
    .i_freeze(frz), .i_stop_in_wait(siw), .i_trigger_mode(tmode), .i_restart(rst_r), .i_trigger(trg),
    .i_abort(abt), .i_load_ok(load_ok_bit), .o_in_lowpower(in_lp), .o_busy(cbusy));
  alpf_properties #(.CONV_CYCLES(8)) i_alpf_properties (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .stop_req(lnk.stop_req), .wait_req(lnk.wait_req), .freeze_req(lnk.freeze_req),
    .trigger_sig(lnk.trigger_sig), .ready(lnk.ready), .busy(lnk.busy), .lowpower_ack(lnk.lowpower_ack));
  ////////////////////////////////////////////////////////////
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  // pulse counters; the ceiling cuts a hang short
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (rstore === 1'b1) n_store++;
    if (adone === 1'b1) n_adone++;
    if (cdone === 1'b1) n_cdone++;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : step
  task automatic kick;
    trg = 1'b1;
    step(1);
    trg = 1'b0;
  endtask : kick
  task automatic wait_done(input int target);
    for (int k = 0; k < 40 && n_cdone < target; k++) step(1);
  endtask : wait_done
  task automatic wait_idle;
    for (int k = 0; k < 60 && lnk.busy !== 1'b0; k++) step(1);
    step(3);
    n_store = 0;
    n_adone = 0;
    n_cdone = 0;
  endtask : wait_idle
  ////////////////////////////////////////////////////////////
  task automatic s_basic;
    chk(8'(rdy), 8'h01);
    chk(8'(flow), 8'h00);
    load_ok_bit = 1'b1;
    step(1);
    load_ok_bit = 1'b0;
    step(1);
    chk(8'(flow[0]), 8'h01);
    kick();
    wait_done(1);
    chk(8'(cidx), 8'h01);
    wr_trg = 1'b1;
    step(1);
    wr_trg = 1'b0;
    wait_done(2);
    chk(8'(cidx), 8'h02);
    wait_idle();
    kick();
    step(3);
    abt = 1'b1;
    step(1);
    abt = 1'b0;
    for (int k = 0; k < 40 && n_adone == 0; k++) step(1);
    chk(8'(n_adone), 8'h01);
    wait_idle();
  endtask : s_basic
  // auto abort on stop or wait, then automatic restart on exit
  task automatic s_lowpower(input logic st, input logic use_wait, input logic mode);
    store = st;
    siw = 1'b1;
    tmode = mode;
    autor = 1'b1;
    kick();
    step(4);
    sel0 = bsel;
    if (use_wait) wt = 1'b1;
    else stop = 1'b1;
    step(2);
    chk(8'(rdy), 8'h00);
    for (int k = 0; k < 30 && lnk.lowpower_ack !== 1'b1; k++) step(1);
    step(1);
    chk(8'(in_lp), 8'h01);
    chk(8'(n_store), 8'(st));
    chk(8'(n_adone), 8'h00);
    rst_r = 1'b1;
    wr_rst = 1'b1;
    step(1);
    rst_r = 1'b0;
    wr_rst = 1'b0;
    step(2);
    chk(8'(flow), 8'h00);
    chk(8'(bsel), 8'(sel0));
    stop = 1'b0;
    wt = 1'b0;
    step(6);
    chk(8'(cidx), 8'h00);
    chk(8'(lnk.busy), 8'(mode));
    wait_idle();
  endtask : s_lowpower
  task automatic s_wait_run;
    siw = 1'b0;
    kick();
    wt = 1'b1;
    wait_done(1);
    chk(8'(n_cdone), 8'h01);
    chk(8'(lnk.lowpower_ack), 8'h00);
    wt = 1'b0;
    wait_idle();
  endtask : s_wait_run
  task automatic s_freeze;
    frzsel = 1'b0;
    list_end = 1'b0;
    kick();
    step(4);
    frz = 1'b1;
    wait_done(1);
    step(6);
    chk(8'(n_cdone), 8'h01);
    chk(8'(lnk.busy), 8'h00);
    frz = 1'b0;
    step(6);
    chk(8'(lnk.busy), 8'h01);
    list_end = 1'b1;
    wait_idle();
    frzsel = 1'b1;
    frz = 1'b1;
    kick();
    wait_done(1);
    chk(8'(n_cdone), 8'h01);
    frz = 1'b0;
    wait_idle();
  endtask : s_freeze
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("mismatches %0d of %0d compared", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial
  begin
    {store, siw, autor, frzsel, tmode, list_end, wr_rst, wr_trg, wr_abt, wr_load_ok_bit} = '0;
    {stop, wt, frz, rst_r, trg, abt, load_ok_bit} = '0;
    acc = 2'h3;
    list_end = 1'b1;
    i_rst = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk) i_rst = 1'b0;
    s_basic();
    s_lowpower(1'b1, 1'b0, 1'b1);
    s_lowpower(1'b0, 1'b1, 1'b0);
    s_wait_run();
    s_freeze();
    conclude();
  end
endmodule : tb
